// ===== common/wss_pkg.sv
// Constants, register map and field layouts of the waveform steering and shutdown block.
// Assumes an 8-bit register port and a single 125 MHz clock.
//
// Summary of operation
// - Steered output carries waveform with polarity applied
// - Upper nibble holds override levels D to A
// - Steering bits act only in modes 00x
// - Synchronous steering double-buffers steering enables
// - Shutdown status set by hardware during shutdown
// - Pair code sets B and D shutdown level
// - Pair code sets A and C shutdown level
// - Code 00 gives inactive level after dead-band
// - Software may set shutdown while module disabled
// - Shutdown held until next data rising edge
// - Five enables admit the five shutdown sources
// - Rising dead-band delays N to N+1 clocks
// - Zero rising count bypasses dead-band
// - Auto-restart clears status once sources gone
// - Software clear ignored while source still active
// - Mode 001 synchronous, 000 asynchronous steering
package wss_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_STEER = 3'h0;
    localparam logic [2:0] ADDR_SDCTL = 3'h1;
    localparam logic [2:0] ADDR_SRCEN = 3'h2;
    localparam logic [2:0] ADDR_RISEDB = 3'h3;
    localparam logic [2:0] ADDR_CTRL = 3'h4;
    localparam logic [2:0] ADDR_IRQSTAT = 3'h5;
    localparam logic [2:0] ADDR_IRQMASK = 3'h6;

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] STEER_RESET = 8'h00;
    localparam logic [7:0] SDCTL_RESET = 8'h14;
    localparam logic [7:0] SDCTL_MASK = 8'hfc;
    localparam logic [7:0] SRCEN_MASK = 8'h1f;
    localparam logic [7:0] RISEDB_MASK = 8'h3f;
    localparam logic [1:0] IRQ_MASK = 2'h3;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
    localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
    localparam logic [2:0] MODE_FB_FWD = 3'h2;
    localparam logic [2:0] MODE_FB_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSHPULL = 3'h5;
    localparam logic [1:0] SD_DRIVE_ONE = 2'h3;
    localparam logic [1:0] SD_DRIVE_ZERO = 2'h2;
    localparam logic [1:0] SD_TRISTATE = 2'h1;
    localparam logic [1:0] SD_INACTIVE = 2'h0;
    localparam int IRQ_SHUTDOWN = 0;
    localparam int IRQ_RESUME = 1;
    localparam int NUM_OUT = 4;
    localparam int NUM_SRC = 5;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] overrideLevel;
        logic [3:0] steerEnable;
    } wss_steer_t;

    typedef struct packed {
        logic shutdown;
        logic restartEn;
        logic [1:0] shutdownStatePairBd;
        logic [1:0] shutdownStatePairAc;
        logic [1:0] unused;
    } wss_sdctl_t;

    typedef struct packed {
        logic enable;
        logic [2:0] mode;
        logic [3:0] invertOutput;
    } wss_ctrl_t;

endpackage : wss_pkg

// ===== hw/wss_top.sv
// Waveform steering, auto-shutdown and rising dead-band for four bridge outputs.
// Assumes the data waveform and shutdown sources are synchronous to clock,
// and a register master that never issues read and write in one cycle.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module wss_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic [wss_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic irq,
    input wire logic dataIn,
    input wire logic pinMappedInput,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic logicCell2Out,
    input wire logic logicCell4Out,
    output logic [3:0] waveformOut,
    output logic [3:0] waveformOutEn
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    wss_pkg::wss_steer_t steer_q, steer_d;
    wss_pkg::wss_sdctl_t sdctl_q, sdctl_d;
    logic [4:0] srcEn_q, srcEn_d;
    logic [5:0] riseDb_q, riseDb_d;
    wss_pkg::wss_ctrl_t ctrl_q, ctrl_d;
    logic [1:0] irqStat_q, irqStat_d;
    logic [1:0] irqMask_q, irqMask_d;
    logic [7:0] rdData_q, rdData_d;
    logic irq_q, irq_d;

    // ----------------------------------------------------------------
    // Datapath state
    // ----------------------------------------------------------------
    logic dataPrev_q, dataPrev_d;
    logic [5:0] riseCnt_q, riseCnt_d;
    logic riseWave_q, riseWave_d;
    logic [3:0] steerActive_q, steerActive_d;
    logic holdShutdown_q, holdShutdown_d;
    logic [5:0] sdCnt_q, sdCnt_d;
    logic ppPhase_q, ppPhase_d;
    logic [3:0] out_q, out_d;
    logic [3:0] oe_q, oe_d;

    logic [4:0] sources;
    logic srcActive;
    logic dataRise;
    logic wave;
    logic steerMode;
    logic [3:0] normalOut;
    logic wrSd;
    logic sdClearOk;

    assign sources = {logicCell4Out, logicCell2Out, comparator2Out, comparator1Out,
                      pinMappedInput};
    assign srcActive = |(sources & srcEn_q);
    assign dataRise = dataIn & ~dataPrev_q;
    assign wave = (riseDb_q == 6'h00) ? dataIn : riseWave_q;
    assign steerMode = (ctrl_q.mode[2:1] == 2'h0);
    assign wrSd = regWrite && (regAddr == wss_pkg::ADDR_SDCTL);
    // A clear only counts once every enabled source has gone away
    assign sdClearOk = ~srcActive;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_comb begin
        steer_d = steer_q;
        sdctl_d = sdctl_q;
        srcEn_d = srcEn_q;
        riseDb_d = riseDb_q;
        ctrl_d = ctrl_q;
        irqStat_d = irqStat_q;
        irqMask_d = irqMask_q;
        rdData_d = 8'h00;
        if (regWrite) begin
            case (regAddr)
                wss_pkg::ADDR_STEER: steer_d = regWrData;
                wss_pkg::ADDR_SDCTL: begin
                    sdctl_d = regWrData & wss_pkg::SDCTL_MASK;
                    // Software may set it at any time, enabled or not
                    if (!regWrData[7] && !sdClearOk) begin
                        sdctl_d.shutdown = sdctl_q.shutdown;
                    end
                    if (!regWrData[7] && !sdctl_q.shutdown) begin
                        sdctl_d.shutdown = 1'b0;
                    end
                end
                wss_pkg::ADDR_SRCEN: srcEn_d = regWrData[4:0];
                wss_pkg::ADDR_RISEDB: riseDb_d = regWrData[5:0];
                wss_pkg::ADDR_CTRL: ctrl_d = regWrData;
                wss_pkg::ADDR_IRQMASK: irqMask_d = regWrData[1:0];
                default: ;
            endcase
        end
        // Automatic restart once the sources are quiet
        if (sdctl_q.restartEn && !srcActive && !wrSd) begin
            sdctl_d.shutdown = 1'b0;
        end
        // Hardware set wins over any clear in the same cycle
        if (srcActive) begin
            sdctl_d.shutdown = 1'b1;
        end
        if (regRead) begin
            case (regAddr)
                wss_pkg::ADDR_STEER: rdData_d = steer_q;
                wss_pkg::ADDR_SDCTL: rdData_d = sdctl_q & wss_pkg::SDCTL_MASK;
                wss_pkg::ADDR_SRCEN: rdData_d = {3'h0, srcEn_q};
                wss_pkg::ADDR_RISEDB: rdData_d = {2'h0, riseDb_q};
                wss_pkg::ADDR_CTRL: rdData_d = ctrl_q;
                wss_pkg::ADDR_IRQSTAT: rdData_d = {6'h00, irqStat_q};
                wss_pkg::ADDR_IRQMASK: rdData_d = {6'h00, irqMask_q};
                default: rdData_d = 8'h00;
            endcase
            if (regAddr == wss_pkg::ADDR_IRQSTAT) begin
                irqStat_d = 2'h0;
            end
        end
        // Events set after the read clear so none is lost
        if (sdctl_d.shutdown && !sdctl_q.shutdown) begin
            irqStat_d[wss_pkg::IRQ_SHUTDOWN] = 1'b1;
        end
        if (holdShutdown_q && !holdShutdown_d) begin
            irqStat_d[wss_pkg::IRQ_RESUME] = 1'b1;
        end
        irq_d = |(irqStat_d & irqMask_d);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            steer_q <= wss_pkg::STEER_RESET;
            sdctl_q <= wss_pkg::SDCTL_RESET;
            srcEn_q <= 5'h00;
            riseDb_q <= 6'h00;
            ctrl_q <= 8'h00;
            irqStat_q <= 2'h0;
            irqMask_q <= 2'h0;
            rdData_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            steer_q <= steer_d;
            sdctl_q <= sdctl_d;
            srcEn_q <= srcEn_d;
            riseDb_q <= riseDb_d;
            ctrl_q <= ctrl_d;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            rdData_q <= rdData_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // Rising dead-band, steering buffer and shutdown hold
    // ----------------------------------------------------------------
    always_comb begin
        dataPrev_d = dataIn;
        riseCnt_d = riseCnt_q;
        riseWave_d = riseWave_q;
        // Falling edge drops riseWave_q one clock later; rising edge waits N clocks
        if (!dataIn) begin
            riseCnt_d = 6'h00;
            riseWave_d = 1'b0;
        end else if (!riseWave_q) begin
            if (riseCnt_q + 6'h01 >= riseDb_q) begin
                riseWave_d = 1'b1;
            end else begin
                riseCnt_d = riseCnt_q + 6'h01;
            end
        end
        steerActive_d = steerActive_q;
        if (ctrl_q.mode == wss_pkg::MODE_ASYNC_STEER) begin
            steerActive_d = steer_q.steerEnable;
        end else if (ctrl_q.mode == wss_pkg::MODE_SYNC_STEER && dataRise) begin
            steerActive_d = steer_q.steerEnable;
        end
        ppPhase_d = dataRise ? ~ppPhase_q : ppPhase_q;
        holdShutdown_d = holdShutdown_q;
        if (sdctl_q.shutdown) begin
            holdShutdown_d = 1'b1;
        end else if (dataRise && ctrl_q.enable) begin
            holdShutdown_d = 1'b0;
        end
        sdCnt_d = sdCnt_q;
        if (!holdShutdown_q) begin
            sdCnt_d = 6'h00;
        end else if (sdCnt_q < riseDb_q) begin
            sdCnt_d = sdCnt_q + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Output selection
    // ----------------------------------------------------------------
    always_comb begin
        normalOut = 4'h0;
        case (ctrl_q.mode)
            wss_pkg::MODE_ASYNC_STEER, wss_pkg::MODE_SYNC_STEER: normalOut = 4'h0;
            wss_pkg::MODE_FB_FWD: normalOut = {wave, 2'h0, 1'b1};
            wss_pkg::MODE_FB_REV: normalOut = {1'b0, 1'b1, wave, 1'b0};
            wss_pkg::MODE_HALF: normalOut = {1'b0, 1'b0, ~dataIn, wave};
            wss_pkg::MODE_PUSHPULL: normalOut = {2'h0, wave & ppPhase_q, wave & ~ppPhase_q};
            default: normalOut = 4'h0;
        endcase
    end

    for (genvar i = 0; i < wss_pkg::NUM_OUT; i++) begin : gOut
        logic [1:0] code;
        logic level;
        assign code = (i % 2 == 1) ? sdctl_q.shutdownStatePairBd
                                   : sdctl_q.shutdownStatePairAc;
        always_comb begin
            if (steerMode) begin
                level = steerActive_q[i] ? (wave ^ ctrl_q.invertOutput[i])
                                         : steer_q.overrideLevel[i];
            end else begin
                level = normalOut[i] ^ ctrl_q.invertOutput[i];
            end
            out_d[i] = out_q[i];
            oe_d[i] = 1'b1;
            if (holdShutdown_q) begin
                case (code)
                    wss_pkg::SD_DRIVE_ONE: out_d[i] = 1'b1;
                    wss_pkg::SD_DRIVE_ZERO: out_d[i] = 1'b0;
                    wss_pkg::SD_TRISTATE: oe_d[i] = 1'b0;
                    default: begin
                        // Hold the last level until the dead-band has run out
                        if (sdCnt_q >= riseDb_q) begin
                            out_d[i] = ctrl_q.invertOutput[i];
                        end
                    end
                endcase
            end else if (!ctrl_q.enable) begin
                out_d[i] = 1'b0;
                oe_d[i] = 1'b0;
            end else begin
                out_d[i] = level;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataPrev_q <= 1'b0;
            riseCnt_q <= 6'h00;
            riseWave_q <= 1'b0;
            steerActive_q <= 4'h0;
            // Start-up is from the shutdown state
            holdShutdown_q <= 1'b1;
            sdCnt_q <= 6'h00;
            ppPhase_q <= 1'b0;
            out_q <= 4'h0;
            oe_q <= 4'h0;
        end else begin
            dataPrev_q <= dataPrev_d;
            riseCnt_q <= riseCnt_d;
            riseWave_q <= riseWave_d;
            steerActive_q <= steerActive_d;
            holdShutdown_q <= holdShutdown_d;
            sdCnt_q <= sdCnt_d;
            ppPhase_q <= ppPhase_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign regRdData = rdData_q;
    assign irq = irq_q;
    assign waveformOut = out_q;
    assign waveformOutEn = oe_q;

endmodule : wss_top

`default_nettype wire

// ===== dv/wss_top_properties.sv
// Port-level checker for the waveform steering and shutdown block.
// Assumes it is bound to wss_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module wss_top_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic [wss_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic irq,
    input wire logic pinMappedInput,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic logicCell2Out,
    input wire logic logicCell4Out,
    input wire logic [3:0] waveformOut,
    input wire logic [3:0] waveformOutEn
);
    // ----------------------------------------------------------------
    // Register shadows, so no view of the internals is needed
    // ----------------------------------------------------------------
    logic [4:0] srcEn_q;
    logic [3:0] pairs_q;
    logic [1:0] mask_q;
    logic srcHit;

    assign srcHit = |(srcEn_q & {logicCell4Out, logicCell2Out, comparator2Out,
        comparator1Out, pinMappedInput});

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            srcEn_q <= 5'h00;
            pairs_q <= 4'h5;
            mask_q <= 2'h0;
        end else if (regWrite) begin
            case (regAddr)
                wss_pkg::ADDR_SRCEN: srcEn_q <= regWrData[4:0];
                wss_pkg::ADDR_SDCTL: pairs_q <= regWrData[5:2];
                wss_pkg::ADDR_IRQMASK: mask_q <= regWrData[1:0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff reset;

    a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside its slot");
    a_status_reads_one: assert property ($past(srcHit) && regRead
        && regAddr == wss_pkg::ADDR_SDCTL |=> regRdData[7])
        else $error("shutdown status not seen while source active");
    a_tristate_pair: assert property (srcHit && pairs_q == 4'h5
        |-> ##3 waveformOutEn == 4'h0)
        else $error("outputs not released for tri-state code");
    a_drive_level: assert property (srcHit && pairs_q[3] && pairs_q[1]
        |-> ##3 waveformOutEn == 4'hf
        && waveformOut == {pairs_q[2], pairs_q[0], pairs_q[2], pairs_q[0]})
        else $error("shutdown drive level wrong");
    a_srcen_unused: assert property ($past(regRead)
        && $past(regAddr) == wss_pkg::ADDR_SRCEN |-> regRdData[7:5] == 3'h0)
        else $error("source enable spare bits not zero");
    a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) == 3'h7
        |-> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq)
        else $error("interrupt raised while masked");
    a_steer_rw: assert property (regWrite && regAddr == wss_pkg::ADDR_STEER
        ##2 regRead && regAddr == wss_pkg::ADDR_STEER |=> regRdData == $past(regWrData, 3))
        else $error("steering register readback wrong");
    a_rise_rw: assert property (regWrite && regAddr == wss_pkg::ADDR_RISEDB
        ##2 regRead && regAddr == wss_pkg::ADDR_RISEDB
        |=> regRdData == ($past(regWrData, 3) & wss_pkg::RISEDB_MASK))
        else $error("rising count readback wrong");
endmodule : wss_top_properties

bind wss_top wss_top_properties wss_top_properties_inst (.clock(clock), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .irq(irq), .pinMappedInput(pinMappedInput),
    .comparator1Out(comparator1Out), .comparator2Out(comparator2Out),
    .logicCell2Out(logicCell2Out), .logicCell4Out(logicCell4Out),
    .waveformOut(waveformOut), .waveformOutEn(waveformOutEn));

`default_nettype wire

// ===== dv/wss_bridge_model.sv
// Bridge switch driver seen from the four outputs.
// Assumes each gate input carries a pull-down, so a released pin reads low.
`timescale 1ns/10ps
`default_nettype none

module wss_bridge_model (
    input wire logic [3:0] waveformOut,
    input wire logic [3:0] waveformOutEn,
    output logic [3:0] pinLevel
);
    // A tri-stated output must not pass for a driven one
    assign pinLevel = waveformOut & waveformOutEn;
endmodule : wss_bridge_model

`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the steering and shutdown block.
// Assumes wss_top, its checker and the bridge model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clock, reset, regWrite, regRead, dataIn, irq;
    logic [2:0] regAddr;
    logic [7:0] regWrData, regRdData, rdv;
    logic [4:0] srcVec;
    logic [3:0] waveformOut, waveformOutEn, pinLevel;
    int fails, compares, d0, dn;

    wss_top wss_top_inst (.clock(clock), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .irq(irq), .dataIn(dataIn), .pinMappedInput(srcVec[0]), .comparator1Out(srcVec[1]),
        .comparator2Out(srcVec[2]), .logicCell2Out(srcVec[3]), .logicCell4Out(srcVec[4]),
        .waveformOut(waveformOut), .waveformOutEn(waveformOutEn));
    wss_bridge_model wss_bridge_model_inst (.waveformOut(waveformOut),
        .waveformOutEn(waveformOutEn), .pinLevel(pinLevel));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Bus, wait and compare helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        rdv = regRdData;
    endtask : rd
    // Pins are judged a few cycles on, past any output pipeline
    task automatic ck(input logic [7:0] e);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk({waveformOutEn, pinLevel}, e);
    endtask : ck
    task automatic pulse();
        @(posedge clock) dataIn <= 1'b0;
        @(posedge clock) dataIn <= 1'b1;
    endtask : pulse
    task automatic dly(output int d);
        @(posedge clock) dataIn <= 1'b0;
        repeat (70) @(posedge clock);
        dataIn <= 1'b1;
        d = 0;
        while (waveformOut[0] !== 1'b1 && d < 100) begin
            @(negedge clock);
            d++;
        end
    endtask : dly

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [2:0] a [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        logic [7:0] r [5] = '{8'h00, 8'h14, 8'h00, 8'h00, 8'h00};
        logic [2:0] w [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
        logic [7:0] m [4] = '{8'hff, 8'h1f, 8'h3f, 8'h00};
        ck(8'h00);
        foreach (a[i]) begin
            rd(a[i]);
            chk(rdv, r[i]);
        end
        foreach (w[i]) begin
            wr(w[i], 8'hff);
            rd(w[i]);
            chk(rdv, m[i]);
            wr(w[i], 8'h00);
        end
    endtask : t_regs
    task automatic t_codes();
        wr(3'h1, 8'hb8);
        rd(3'h1);
        chk(rdv, 8'hb8);
        ck(8'hfa);
        wr(3'h1, 8'ha4);
        ck(8'ha0);
        wr(3'h1, 8'h9c);
        ck(8'h55);
        wr(3'h4, 8'h05);
        wr(3'h1, 8'h80);
        ck(8'hf5);
    endtask : t_codes
    task automatic t_steer();
        wr(3'h4, 8'h81);
        wr(3'h0, 8'ha5);
        wr(3'h1, 8'h00);
        ck(8'hf1);
        @(posedge clock) dataIn <= 1'b1;
        ck(8'hfe);
        @(posedge clock) dataIn <= 1'b0;
        ck(8'hfb);
        wr(3'h4, 8'ha1);
        ck(8'hf0);
        chk({7'h0, pinLevel[0]}, 8'h00);
    endtask : t_steer
    task automatic t_deadband();
        int n [3] = '{0, 1, 63};
        wr(3'h4, 8'h80);
        wr(3'h0, 8'h01);
        foreach (n[i]) begin
            wr(3'h3, 8'(n[i]));
            dly(dn);
            if (i == 0) d0 = dn;
            chk({7'h0, dn - d0 >= n[i] && dn - d0 <= n[i] + 1}, 8'h01);
        end
        chk(8'(d0), 8'h02);
        // Later scenarios expect the waveform with no rising delay
        wr(3'h3, 8'h00);
    endtask : t_deadband
    task automatic t_sync();
        wr(3'h4, 8'h90);
        wr(3'h0, 8'h00);
        pulse();
        ck(8'hf0);
        wr(3'h0, 8'h0f);
        ck(8'hf0);
        pulse();
        ck(8'hff);
    endtask : t_sync
    task automatic t_sources();
        wr(3'h4, 8'h80);
        wr(3'h1, 8'h28);
        wr(3'h6, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(3'h2, 8'h00);
            @(posedge clock) srcVec <= 5'(1 << i);
            ck(8'hff);
            wr(3'h2, 8'(1 << i));
            ck(8'hf0);
            chk({7'h0, irq}, 8'h01);
            wr(3'h1, 8'h28);
            rd(3'h1);
            chk(rdv, 8'ha8);
            @(posedge clock) srcVec <= 5'h00;
            rd(3'h5);
            chk(rdv & 8'h01, 8'h01);
            rd(3'h1);
            chk(rdv, 8'ha8);
            wr(3'h1, 8'h28);
            ck(8'hf0);
            pulse();
            ck(8'hff);
            chk({7'h0, irq}, 8'h00);
        end
    endtask : t_sources
    task automatic t_restart();
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h54);
        @(posedge clock) srcVec <= 5'h01;
        ck(8'h00);
        rd(3'h1);
        chk(rdv, 8'hd4);
        @(posedge clock) srcVec <= 5'h00;
        ck(8'h00);
        rd(3'h1);
        chk(rdv, 8'h54);
        pulse();
        ck(8'hff);
    endtask : t_restart
    task automatic t_modes();
        wr(3'h4, 8'hb0);
        ck(8'hf6);
        wr(3'h4, 8'hc0);
        ck(8'hf1);
        // Push-pull phase depends on history, so judge the swap between pulses
        wr(3'h4, 8'hd0);
        pulse();
        repeat (4) @(posedge clock);
        @(negedge clock);
        rdv = {4'h0, pinLevel};
        chk({7'h0, ^rdv[1:0]}, 8'h01);
        pulse();
        ck({4'hf, 2'h0, rdv[0], rdv[1]});
    endtask : t_modes

    task automatic summarize();
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    initial begin
        reset = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        dataIn = 1'b0;
        srcVec = 5'h00;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        t_regs();
        t_codes();
        t_steer();
        t_deadband();
        t_sync();
        t_sources();
        t_restart();
        t_modes();
        summarize();
    end

    // Whole run is under a thousand cycles; this bound leaves ample slack
    initial begin
        #200000;
        fails++;
        summarize();
    end
endmodule : testbench

`default_nettype wire
